// file: hw/tpwm_timer.sv
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Purpose: 16-bit timer channel with pwm and free-running capture/compare modes
// Assumes: count clock is aclk gated by ce; axi4-lite register access
// Notes: other mode field values hold the counter stopped
module tpwm_timer
  import tpwm_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [1:0]        capture_trigger_input,
  output logic                   timer_out_zero,
  output logic                   timer_out_one,
  output logic                   period_match_irq,
  output logic                   duty_match_irq,
  output logic                   counter_wrap_irq
);
  // bus slave state
  logic [ADDR_W-1:0] awaddr_ff;
  logic              aw_hold_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              w_hold_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  // software registers
  logic              counter_run_bit_ff;
  logic [2:0]        timer_mode_field_ff;
  logic              wrap_flag_ff;
  logic [1:0]        capture_select_bit_ff;
  logic [3:0]        edge_sel_ff;
  logic [15:0]       period_compare_reg_ff;
  logic [15:0]       duty_compare_reg_ff;
  // counter core
  logic [15:0]       cnt_ff;
  logic              first_ff;
  logic              armed_ff;
  logic [15:0]       buf0_ff;
  logic [15:0]       buf1_ff;
  logic              out0_ff;
  logic              out1_ff;
  logic              irq0_ff;
  logic              irq1_ff;
  logic              wrap_irq_ff;
  // decode and next values
  logic              do_wr;
  logic              wr_ctrl;
  logic              wr_opt;
  logic              wr_edge;
  logic              wr_period;
  logic              wr_duty;
  logic              wr_err;
  logic [31:0]       rd_data;
  logic              rd_err;
  logic              pwm;
  logic              free;
  logic              tick;
  logic              period_hit;
  logic              load_buf;
  logic              cmp0_hit;
  logic              cmp1_hit;
  logic              wrap_hit;
  logic              cap0;
  logic              cap1;
  logic              toggle_ev;
  logic              flag_clr;
  logic [15:0]       nxt_cnt;
  logic [15:0]       nxt_buf0;
  logic [15:0]       nxt_buf1;
  logic [31:0]       nxt_period;
  logic [31:0]       nxt_duty;

  tpwm_cap_if cap_bus ();

  tpwm_edge_det tpwm_edge_det_inst (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .ce                    (ce),
    .capture_trigger_input (capture_trigger_input),
    .cap                   (cap_bus.det)
  );

  assign cap_bus.edge_sel = edge_sel_ff;

  // handshake outputs; readies forced low and responses frozen while ce is low
  assign s_axi_awready = ce & ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready  = ce & ~w_hold_ff & ~bvalid_ff;
  assign s_axi_arready = ce & ~rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign do_wr         = ce & aw_hold_ff & w_hold_ff & ~bvalid_ff;

  // write address decode
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_opt    = 1'b0;
    wr_edge   = 1'b0;
    wr_period = 1'b0;
    wr_duty   = 1'b0;
    wr_err    = 1'b0;
    if (awaddr_ff == OFS_CTRL) begin
      wr_ctrl = do_wr;
    end else if (awaddr_ff == OFS_OPTION) begin
      wr_opt = do_wr;
    end else if (awaddr_ff == OFS_EDGE) begin
      wr_edge = do_wr;
    end else if (awaddr_ff == OFS_PERIOD) begin
      wr_period = do_wr;
    end else if (awaddr_ff == OFS_DUTY) begin
      wr_duty = do_wr;
    end else if (awaddr_ff != OFS_COUNT) begin
      wr_err = do_wr;
    end
  end

  // read address decode
  always_comb begin
    rd_data = DATA_ZERO;
    rd_err  = 1'b0;
    if (s_axi_araddr == OFS_CTRL) begin
      rd_data[CTRL_RUN_BIT]                  = counter_run_bit_ff;
      rd_data[CTRL_MODE_MSB:CTRL_MODE_LSB]   = timer_mode_field_ff;
    end else if (s_axi_araddr == OFS_OPTION) begin
      rd_data[OPT_FLAG_BIT]                  = wrap_flag_ff;
      rd_data[OPT_SEL0_BIT]                  = capture_select_bit_ff[0];
      rd_data[OPT_SEL1_BIT]                  = capture_select_bit_ff[1];
    end else if (s_axi_araddr == OFS_EDGE) begin
      rd_data[3:0]                           = edge_sel_ff;
    end else if (s_axi_araddr == OFS_PERIOD) begin
      rd_data[15:0]                          = period_compare_reg_ff;
    end else if (s_axi_araddr == OFS_DUTY) begin
      rd_data[15:0]                          = duty_compare_reg_ff;
    end else if (s_axi_araddr == OFS_COUNT) begin
      rd_data[15:0]                          = cnt_ff;
    end else begin
      rd_err = 1'b1;
    end
  end

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff  <= '0;
      w_hold_ff  <= 1'b0;
      wdata_ff   <= DATA_ZERO;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read channel, data registered one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= DATA_ZERO;
      rresp_ff  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_data;
        rresp_ff  <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // counter core decode
  always_comb begin
    pwm        = timer_mode_field_ff == MODE_PWM;
    free       = timer_mode_field_ff == MODE_FREE;
    tick       = ce & counter_run_bit_ff & (pwm | free);
    period_hit = pwm & ~first_ff & (cnt_ff == buf0_ff);
    load_buf   = period_hit & armed_ff;
    cmp0_hit   = free & ~first_ff & ~capture_select_bit_ff[0] & (cnt_ff == period_compare_reg_ff);
    cmp1_hit   = free & ~first_ff & ~capture_select_bit_ff[1] & (cnt_ff == duty_compare_reg_ff);
    wrap_hit   = free & ~first_ff & (cnt_ff == CNT_MAX);
    cap0       = free & capture_select_bit_ff[0] & cap_bus.cap_pulse[0];
    cap1       = free & capture_select_bit_ff[1] & cap_bus.cap_pulse[1];
    nxt_cnt    = period_hit ? CNT_ZERO : cnt_ff + CNT_ONE;
    nxt_buf0   = load_buf ? period_compare_reg_ff : buf0_ff;
    nxt_buf1   = load_buf ? duty_compare_reg_ff : buf1_ff;
    toggle_ev  = free ? (first_ff | cmp0_hit | cmp1_hit) : period_hit;
    flag_clr   = wr_opt & wstrb_ff[0] & ~wdata_ff[OPT_FLAG_BIT];
    nxt_period = tpwm_strb({16'h0000, period_compare_reg_ff}, wdata_ff, wstrb_ff);
    nxt_duty   = tpwm_strb({16'h0000, duty_compare_reg_ff}, wdata_ff, wstrb_ff);
  end

  // control, option and edge registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_run_bit_ff    <= 1'b0;
      timer_mode_field_ff   <= MODE_RST;
      capture_select_bit_ff <= 2'h0;
      edge_sel_ff           <= {EDGE_NONE, EDGE_NONE};
    end else if (ce) begin
      if (wr_ctrl && wstrb_ff[0]) begin
        counter_run_bit_ff  <= wdata_ff[CTRL_RUN_BIT];
        timer_mode_field_ff <= wdata_ff[CTRL_MODE_MSB:CTRL_MODE_LSB];
      end
      if (wr_opt && wstrb_ff[0]) begin
        capture_select_bit_ff <= {wdata_ff[OPT_SEL1_BIT], wdata_ff[OPT_SEL0_BIT]};
      end
      if (wr_edge && wstrb_ff[0]) begin
        edge_sel_ff <= wdata_ff[3:0];
      end
    end
  end

  // sticky wrap flag, a set beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_flag_ff <= 1'b0;
    end else if (ce) begin
      if (tick && wrap_hit) begin
        wrap_flag_ff <= 1'b1;
      end else if (flag_clr) begin
        wrap_flag_ff <= 1'b0;
      end
    end
  end

  // compare/capture registers; a capture beats a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_compare_reg_ff <= CNT_ZERO;
      duty_compare_reg_ff   <= CNT_ZERO;
    end else if (ce) begin
      if (tick && cap0) begin
        period_compare_reg_ff <= cnt_ff;
      end else if (wr_period) begin
        period_compare_reg_ff <= nxt_period[15:0];
      end
      if (tick && cap1) begin
        duty_compare_reg_ff <= cnt_ff;
      end else if (wr_duty) begin
        duty_compare_reg_ff <= nxt_duty[15:0];
      end
    end
  end

  // buffer transfer arming, only a duty write arms
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_ff <= 1'b0;
    end else if (ce) begin
      if (wr_duty && pwm) begin
        armed_ff <= 1'b1;
      end else if (tick && load_buf) begin
        armed_ff <= 1'b0;
      end
    end
  end

  // counter and shadow buffers; stopped counter parks at ffff
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff   <= CNT_MAX;
      first_ff <= 1'b1;
      buf0_ff  <= CNT_ZERO;
      buf1_ff  <= CNT_ZERO;
    end else if (ce) begin
      if (!counter_run_bit_ff) begin
        cnt_ff   <= CNT_MAX;
        first_ff <= 1'b1;
        buf0_ff  <= period_compare_reg_ff;
        buf1_ff  <= duty_compare_reg_ff;
      end else if (tick) begin
        cnt_ff   <= nxt_cnt;
        first_ff <= 1'b0;
        buf0_ff  <= nxt_buf0;
        buf1_ff  <= nxt_buf1;
      end
    end
  end

  // timer outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out0_ff <= 1'b0;
      out1_ff <= 1'b0;
    end else if (tick) begin
      out0_ff <= out0_ff ^ toggle_ev;
      if (pwm) begin
        out1_ff <= nxt_cnt < nxt_buf1;
      end else begin
        out1_ff <= out1_ff ^ toggle_ev;
      end
    end
  end

  // interrupt pulses, one count clock each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq0_ff     <= 1'b0;
      irq1_ff     <= 1'b0;
      wrap_irq_ff <= 1'b0;
    end else if (ce) begin
      irq0_ff     <= tick & (period_hit | cmp0_hit | cap0);
      irq1_ff     <= tick & ((pwm & (nxt_cnt == nxt_buf1)) | cmp1_hit | cap1);
      wrap_irq_ff <= tick & wrap_hit;
    end
  end

  assign timer_out_zero   = out0_ff;
  assign timer_out_one    = out1_ff;
  assign period_match_irq = irq0_ff;
  assign duty_match_irq   = irq1_ff;
  assign counter_wrap_irq = wrap_irq_ff;

  a_pwm_period_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tick && period_hit |=> cnt_ff == CNT_ZERO && period_match_irq)
    else $error("pwm counter did not clear at period match");

  a_duty_arm_source: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(armed_ff) |-> $past(wr_duty))
    else $error("transfer armed without duty write");

  a_shadow_load: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tick && load_buf |=> buf0_ff == $past(period_compare_reg_ff) && buf1_ff == $past(duty_compare_reg_ff))
    else $error("shadow buffers not loaded at clear");

  a_zero_duty_low: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tick && pwm && !load_buf && buf1_ff == CNT_ZERO |=> !timer_out_one)
    else $error("zero duty output went active");

  a_full_duty_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tick && pwm && !load_buf && buf0_ff != CNT_MAX && buf1_ff == buf0_ff + CNT_ONE |=> timer_out_one)
    else $error("full duty output went inactive");

  a_duty_irq_align: assert property (
    @(posedge aclk) disable iff (!aresetn)
    duty_match_irq && pwm && counter_run_bit_ff |-> cnt_ff == buf1_ff)
    else $error("pwm duty irq not on duty count");

  a_cmp_toggle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tick && cmp0_hit |=> period_match_irq && timer_out_zero != $past(timer_out_zero)
                         && cnt_ff == $past(period_compare_reg_ff) + CNT_ONE)
    else $error("compare match missed irq or toggle");

  a_free_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tick && wrap_hit |=> counter_wrap_irq && wrap_flag_ff && cnt_ff == CNT_ZERO)
    else $error("wrap did not flag and clear");

  a_flag_sticky: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wrap_flag_ff && !flag_clr |=> wrap_flag_ff)
    else $error("wrap flag dropped without clear");

  a_capture_copy: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tick && cap1 |=> duty_compare_reg_ff == $past(cnt_ff) && duty_match_irq)
    else $error("capture did not copy count");
endmodule

// file: hw/tpwm_pkg.sv
// Purpose: shared constants for the pwm / free-running timer channel
// Assumes: axi4-lite slave with 32-bit data, one aligned word per register
// Notes: byte offsets below are the register map seen by software
//
// Notes on behaviour
// - mode field 100 selects pwm, run starts
// - pwm period is period+1, active duty counts
// - only a duty write arms buffer transfer
// - armed values load shadows when counter clears
// - duty zero gives inactive output, both irqs
// - duty period+1 gives active; ffff impossible
// - pwm duty irq when count equals duty
// - mode field 101 selects free-running counting
// - compare on all channels, capture where inputs
// - per-register select bit picks capture or compare
// - run start inverts both outputs in compare
// - count reaching d+1 raises irq, toggles outputs
// - after ffff: wrap irq, flag, zero, continue
// - wrap flag sticky until software clears it
// - free-running compare writes act immediately
// - capture edge copies count, raises irq
// - free-running counter never cleared by events
// - readback register returns current count
package tpwm_pkg;
  localparam int          ADDR_W         = 8;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_OPTION     = 8'h04;
  localparam logic [7:0]  OFS_EDGE       = 8'h08;
  localparam logic [7:0]  OFS_PERIOD     = 8'h0c;
  localparam logic [7:0]  OFS_DUTY       = 8'h10;
  localparam logic [7:0]  OFS_COUNT      = 8'h14;
  // field positions
  localparam int          CTRL_RUN_BIT   = 0;
  localparam int          CTRL_MODE_LSB  = 4;
  localparam int          CTRL_MODE_MSB  = 6;
  localparam int          OPT_FLAG_BIT   = 0;
  localparam int          OPT_SEL0_BIT   = 1;
  localparam int          OPT_SEL1_BIT   = 2;
  localparam int          EDGE_CH1_LSB   = 2;
  // mode field encodings
  localparam logic [2:0]  MODE_PWM       = 3'h4;
  localparam logic [2:0]  MODE_FREE      = 3'h5;
  localparam logic [2:0]  MODE_RST       = 3'h0;
  // edge select encodings
  localparam logic [1:0]  EDGE_NONE      = 2'h0;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_FALL      = 2'h2;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;
  // counter values
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CNT_ONE        = 16'h0001;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  // bus answers
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [31:0] DATA_ZERO      = 32'h00000000;

  // merge write data into an old value under byte strobes
  function automatic logic [31:0] tpwm_strb(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction
endpackage

// file: hw/tpwm_cap_if.sv
`timescale 1ns/1ps
// Purpose: carries edge selections and capture pulses between timer and detector
// Assumes: both ends in the aclk domain
// Notes: cap_pulse is combinational, one cycle per detected edge
interface tpwm_cap_if;
  logic [3:0] edge_sel;
  logic [1:0] cap_pulse;
  modport ctrl (output edge_sel, input cap_pulse);
  modport det (input edge_sel, output cap_pulse);
endinterface

// file: hw/tpwm_edge_det.sv
`timescale 1ns/1ps
// Purpose: valid-edge detection on the two capture trigger inputs
// Assumes: inputs synchronous to aclk
// Notes: edge select none masks the input entirely
module tpwm_edge_det
  import tpwm_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic [1:0] capture_trigger_input,
  tpwm_cap_if.det         cap
);
  logic [1:0] prev_ff;

  // decide whether a sample pair is a selected edge
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
    logic hit;
    hit = 1'b0;
    if (sel == EDGE_RISE) begin
      hit = cur & ~prv;
    end else if (sel == EDGE_FALL) begin
      hit = ~cur & prv;
    end else if (sel == EDGE_BOTH) begin
      hit = cur ^ prv;
    end
    return hit;
  endfunction

  // previous input levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff <= 2'h0;
    end else if (ce) begin
      prev_ff <= capture_trigger_input;
    end
  end

  // per-channel edge pulses
  always_comb begin
    cap.cap_pulse[0] = ce & edge_hit(cap.edge_sel[1:0], capture_trigger_input[0], prev_ff[0]);
    cap.cap_pulse[1] = ce & edge_hit(cap.edge_sel[3:2], capture_trigger_input[1], prev_ff[1]);
  end
endmodule

// file: tb/tpwm_trig_model.sv
// Purpose: far-side source for the two capture trigger lines
// Assumes: levels change just after a rising aclk edge
// Notes: line 1 echoes each ch0 irq as an edge, line 0 is noise
`timescale 1ns/1ps
module tpwm_trig_model (
  input  wire logic       aclk,
  input  wire logic       irq,
  output logic [1:0]      trig
);
  initial trig = 2'h0;
  // toggle line 1 per irq; line 0 random while its edge select is none
  always @(posedge aclk) begin
    if (irq) trig[1] <= ~trig[1];
    trig[0] <= 1'($urandom);
  end
endmodule

// file: tb/tb_tpwm_timer.sv
// Purpose: self-checking bench for the pwm / free-running timer
// Assumes: ce held high, bus driven by nba after rising edges
// Notes: read data checked by a monitor against a queue of notes
`timescale 1ns/1ps
module tb_tpwm_timer;
  import tpwm_pkg::*;
  logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [1:0]  trig;
  wire         awready, wready, bvalid, arready, rvalid, out0, out1, pirq, dirq, wirq;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  logic [33:0] expq[$];
  int          miscompares, cmp_count;
  int          tp[6] = '{9, 9, 9, 4, 7, 7};
  int          td[6] = '{3, 0, 10, 2, -1, 2};
  int          ep[6] = '{10, 10, 10, 5, 5, 8};
  int          eh[6] = '{3, 0, 10, 2, 2, 2};
  int          ed[6] = '{3, 0, 'hffff, 2, 2, 2};

  tpwm_timer tpwm_timer_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_trigger_input(trig), .timer_out_zero(out0), .timer_out_one(out1),
    .period_match_irq(pirq), .duty_match_irq(dirq), .counter_wrap_irq(wirq));
  tpwm_trig_model tpwm_trig_model_inst (.aclk(aclk), .irq(pirq), .trig(trig));

  // 10 mhz clock
  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one write, held until each channel is taken and bvalid seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    // bready stays high; unmapped or unaligned offsets answer with an error
    chk(34'(bresp), 34'((a <= OFS_COUNT && a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR));
    if (n >= 200) miscompares++;
  endtask

  // one read; expected answer noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    expq.push_back(e);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    if (n >= 200) miscompares++;
  endtask

  // wait for a ch0 irq pulse, bounded
  task automatic wait_pirq();
    int n;
    n = 0;
    do @(posedge aclk); while (!pirq && ++n < 300);
    if (n >= 300) miscompares++;
  endtask

  // measure one pwm period after the shadows have loaded
  task automatic meas(input int p, input int h, input int d);
    int n, hi, dq;
    n  = 0;
    hi = 0;
    dq = 'hffff;
    wait_pirq();
    wait_pirq();
    do begin
      if (out1) hi++;
      if (dirq && dq == 'hffff) dq = n;
      n++;
      @(posedge aclk);
    end while (!pirq && n < 300);
    chk(34'(n), 34'(p));
    chk(34'(hi), 34'(h));
    chk(34'(dq), 34'(d));
  endtask

  // monitor: each read answer against the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, expq.size() > 0 ? expq.pop_front() : '1);
  end

  // watchdog
  initial begin
    #9000000;
    miscompares++;
    summarize();
  end

  initial begin
    logic [15:0] dv;
    logic        o0;
    logic [1:0]  es;
    int          n;
    ce = 1'b1;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    void'($urandom(34579));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_COUNT, {RESP_OKAY, 16'h0, CNT_MAX});
    rd(8'h3c, {RESP_SLVERR, DATA_ZERO});
    wr(8'h3c, 32'h1, 4'hf);
    // pwm: both, 0%, 100%, both, period-only unarmed, then armed
    for (int i = 0; i < 6; i++) begin
      wr(OFS_PERIOD, 32'(tp[i]), 4'hf);
      if (td[i] >= 0) wr(OFS_DUTY, 32'(td[i]), 4'hf);
      if (i == 0) wr(OFS_CTRL, {25'h0, MODE_PWM, 3'h0, 1'b1}, 4'hf);
      meas(ep[i], eh[i], ed[i]);
    end
    // free-running: ch0 compare, ch1 capture on the edge the echo line makes next
    wr(OFS_CTRL, DATA_ZERO, 4'hf);
    wr(OFS_OPTION, 32'h4, 4'hf);
    // echo line is idle now; pick the edge its next toggle makes
    es = trig[1] ? EDGE_FALL : EDGE_RISE;
    wr(OFS_EDGE, {28'h0, es, EDGE_NONE}, 4'hf);
    dv = 16'(20 + $urandom % 100);
    wr(OFS_PERIOD, {16'h0, dv}, 4'hf);
    o0 = out0;
    wr(OFS_CTRL, {25'h0, MODE_FREE, 3'h0, 1'b1}, 4'hf);
    repeat (3) @(posedge aclk);
    chk(34'(out0), {33'h0, ~o0});
    wait_pirq();
    chk(34'(out0), 34'(o0));
    repeat (4) @(posedge aclk);
    rd(OFS_DUTY, {RESP_OKAY, 16'h0, dv + 16'h2});
    // live compare rewrites: opposite edge, then both; each capture overwrites
    for (int j = 1; j < 3; j++) begin
      es = (j == 2) ? EDGE_BOTH : ((es == EDGE_RISE) ? EDGE_FALL : EDGE_RISE);
      wr(OFS_EDGE, {28'h0, es, EDGE_NONE}, 4'hf);
      wr(OFS_PERIOD, {16'h0, dv + 16'(j * 50)}, 4'hf);
      wait_pirq();
      repeat (4) @(posedge aclk);
      rd(OFS_DUTY, {RESP_OKAY, 16'h0, dv + 16'(j * 50 + 2)});
    end
    // wrap after ffff, sticky flag, then clear
    n = 0;
    do @(posedge aclk); while (!wirq && ++n < 70000);
    if (n >= 70000) miscompares++;
    repeat (2) @(posedge aclk);
    rd(OFS_OPTION, {RESP_OKAY, 32'h5});
    wr(OFS_OPTION, 32'h5, 4'h1);
    rd(OFS_OPTION, {RESP_OKAY, 32'h5});
    wr(OFS_OPTION, 32'h4, 4'h1);
    rd(OFS_OPTION, {RESP_OKAY, 32'h4});
    repeat (4) @(posedge aclk);
    summarize();
  end
endmodule
